// ===== hw/wsc_comparator.sv
// single setpoint comparator with lead compensation, learning and tolerance pause
// assumes one ahb-lite master, weight inputs synchronous to hclk
//
// How it works
// (RULE_01) scale select chooses the weight source
// (RULE_02) four satisfy conditions: above, below, inside, outside
// (RULE_03) batch above: output on until weight reaches target
// (RULE_04) batch below: output on until weight below target
// (RULE_05) window band is target plus/minus half width
// (RULE_06) once off, rearm only beyond rearm margin
// (RULE_07) fixed lead shifts trip toward approach side
// (RULE_08) adaptive lead adds factor times standstill error
// (RULE_09) rate mode predicts crossing from weight slope
// (RULE_10) correction factor in millionths, default half
// (RULE_11) settle timeout in tenths skips learning
// (RULE_12) learn only every interval completed batches
// (RULE_13) out-of-tolerance capture skips learning
// (RULE_14) tolerance failure pauses until restart/reset
// (RULE_15) pause after consecutive fail count; zero never
// (RULE_16) target weight held, range up to max
// (RULE_17) evaluate once per sample strobe, next edge
// (RULE_18) signed lead arithmetic clamped to weight range
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
module wsc_comparator #(
    parameter int NUM_SCALES  = 4,
    parameter int TICK_CYCLES = wsc_pkg::SETTLE_TICK_CYCLES
) (
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic      [31:0]                    hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic [NUM_SCALES*wsc_pkg::WW-1:0] scale_weight,
    input  wire logic                           sample_valid,
    input  wire logic                           standstill,
    input  wire logic                           batch_done,
    output logic                                setpoint_out,
    output logic                                batch_paused,
    output logic                                irq
);
    import wsc_pkg::*;

    typedef logic signed [WW+2:0] wsc_sw_t;

    function automatic wsc_sw_t sx(input logic [WW-1:0] v);
        sx = wsc_sw_t'({3'b000, v});
    endfunction

    function automatic logic [WW-1:0] absdiff(input logic [WW-1:0] a, input logic [WW-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [9:0]    ctrl_reg,     ctrl_next;
    logic [WW-1:0] target_reg,   target_next;
    logic [WW-1:0] band_reg,     band_next;
    logic [WW-1:0] rearm_reg,    rearm_next;
    logic [WW-1:0] lead_reg,     lead_next;
    logic [WW-1:0] factor_reg,   factor_next;
    logic [15:0]   settle_reg,   settle_next;
    logic [15:0]   interval_reg, interval_next;
    logic [WW-1:0] tol_reg,      tol_next;
    logic [15:0]   tolerance_fail_count_reg,   tolerance_fail_count_next;
    logic [2:0]    istat_reg,    istat_next;
    logic [2:0]    imask_reg,    imask_next;
    logic [7:0]    aaddr_reg,    aaddr_next;
    logic          awr_reg,      awr_next;
    logic [31:0]   hrdata_reg,   hrdata_next;
    logic          irq_reg,      irq_next;
    logic          out_reg,      out_next;
    logic          armed_reg,    armed_next;
    logic          paused_reg,   paused_next;
    logic [WW-1:0] prev_w_reg,   prev_w_next;
    logic [15:0]   fail_reg,     fail_next;
    logic [15:0]   bcnt_reg,     bcnt_next;
    logic [15:0]   tenth_reg,    tenth_next;
    logic [31:0]   tick_reg,     tick_next;
    logic [WW-1:0] capt_reg,     capt_next;
    wsc_lrn_e      lrn_reg,      lrn_next;
    logic          rdy_reg,      rdy_next;

    logic          addr_ok, wr_en, lead_wr, cmd_clr, sat, beyond, in_tol, pause_evt;
    logic [WW-1:0] weight;
    wsc_cond_e     cond;
    wsc_lead_e     lmode;
    wsc_sw_t       w_s, trip_pt, pred, err, lead_s;
    logic signed [WW+26:0] prod;

    assign cond  = wsc_cond_e'(ctrl_reg[CTRL_COND_LSB +: 2]);
    assign lmode = wsc_lead_e'(ctrl_reg[CTRL_LEAD_LSB +: 2]);
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_en   = awr_reg;
    assign lead_wr = wr_en && (aaddr_reg == OFS_LEAD);
    assign cmd_clr = wr_en && (aaddr_reg == OFS_CMD) && (hwdata[CMD_RESTART_BIT] || hwdata[CMD_RESET_BIT]);
    // violation that reaches the fail count in this cycle
    assign pause_evt = (lrn_reg == LRN_UPDATE) && !in_tol && (tolerance_fail_count_reg != 16'h0)
                       && (fail_reg + 16'h1 >= tolerance_fail_count_reg);

    ////////////////////////////////////////////////////////////////////////
    // comparison path
    always_comb begin
        weight = scale_weight[WW-1:0];
        for (int i = 0; i < NUM_SCALES; i++) begin
            if (ctrl_reg[CTRL_SCALE_LSB +: 3] == 3'(i)) begin
                weight = scale_weight[i*WW +: WW]; // [RULE_01]
            end
        end
        w_s  = sx(weight);
        pred = w_s + (w_s - sx(prev_w_reg)); // [RULE_09]
        trip_pt = sx(target_reg);
        if (lmode != LEAD_OFF) begin
            // approach from below for above, from above for below
            trip_pt = (cond == COND_BELOW) ? sx(target_reg) + sx(lead_reg) : sx(target_reg) - sx(lead_reg); // [RULE_07]
        end
        if (lmode == LEAD_RATE) begin
            w_s = pred; // [RULE_09]
        end
        case (cond)
            COND_ABOVE:  sat = w_s >= trip_pt; // [RULE_02] [RULE_03]
            COND_BELOW:  sat = w_s < trip_pt; // [RULE_02] [RULE_04]
            COND_INSIDE: sat = absdiff(weight, target_reg) <= band_reg; // [RULE_05]
            COND_OUTSIDE: sat = absdiff(weight, target_reg) > band_reg; // [RULE_05]
            default:     sat = 1'b0;
        endcase
        beyond = absdiff(weight, target_reg) > rearm_reg; // [RULE_06]
        in_tol = absdiff(capt_reg, target_reg) <= tol_reg; // [RULE_13]
        err = (cond == COND_BELOW) ? sx(target_reg) - sx(capt_reg) : sx(capt_reg) - sx(target_reg); // [RULE_08]
        prod = (WW+27)'(err) * $signed({1'b0, factor_reg}); // [RULE_10]
        lead_s = sx(lead_reg) + wsc_sw_t'(prod / FACTOR_ONE); // [RULE_18]
    end

    ////////////////////////////////////////////////////////////////////////
    // setpoint state, learning and pause
    always_comb begin
        out_next    = out_reg;
        armed_next  = armed_reg;
        prev_w_next = prev_w_reg;
        paused_next = paused_reg;
        fail_next   = fail_reg;
        bcnt_next   = bcnt_reg;
        tenth_next  = tenth_reg;
        tick_next   = tick_reg;
        capt_next   = capt_reg;
        lrn_next    = lrn_reg;
        lead_next   = lead_reg;
        istat_next  = istat_reg;
        if (sample_valid) begin // [RULE_17]
            prev_w_next = weight;
            if (armed_reg) begin
                out_next = ctrl_reg[CTRL_EN_BIT] && !paused_reg && (ctrl_reg[CTRL_BATCH_BIT] ? !sat : sat); // [RULE_03] [RULE_04]
                // batch trips on satisfy; continuous disarms when the output drops
                if (ctrl_reg[CTRL_BATCH_BIT] ? sat : (out_reg && !sat)) begin
                    armed_next = 1'b0; // [RULE_06]
                    out_next = 1'b0;
                    istat_next[IRQ_TRIP_BIT] = 1'b1;
                end
            end else if (beyond) begin
                armed_next = 1'b1; // [RULE_06]
            end
        end
        // the tenth tick runs free; timer resolution is one tick
        tick_next = (tick_reg >= 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_reg + 32'h1;
        case (lrn_reg)
            LRN_IDLE: begin
                if (batch_done && (cond == COND_ABOVE || cond == COND_BELOW)) begin
                    lrn_next   = LRN_SETTLE;
                    tenth_next = 16'h0;
                end
            end
            LRN_SETTLE: begin
                if (tick_reg == 32'h0) begin
                    tenth_next = tenth_reg + 16'h1;
                end
                if (sample_valid && standstill) begin
                    capt_next = weight;
                    lrn_next  = LRN_UPDATE;
                end else if (settle_reg != 16'h0 && tenth_reg >= settle_reg) begin
                    lrn_next = LRN_IDLE; // [RULE_11]
                end
            end
            LRN_UPDATE: begin
                lrn_next = LRN_IDLE;
                if (!in_tol) begin
                    fail_next = fail_reg + 16'h1; // [RULE_13]
                    if (pause_evt) begin
                        paused_next = 1'b1; // [RULE_14] [RULE_15]
                        istat_next[IRQ_PAUSE_BIT] = 1'b1;
                    end
                end else begin
                    fail_next = 16'h0;
                    if (lmode == LEAD_ADAPT && interval_reg != 16'h0) begin
                        bcnt_next = bcnt_reg + 16'h1;
                        if (bcnt_reg + 16'h1 >= interval_reg) begin // [RULE_12]
                            bcnt_next = 16'h0;
                            istat_next[IRQ_LEARN_BIT] = 1'b1;
                            if (lead_s < 0) lead_next = RST_ZERO; // [RULE_18]
                            else if (lead_s > sx(MAX_WEIGHT)) lead_next = MAX_WEIGHT;
                            else lead_next = lead_s[WW-1:0]; // [RULE_08]
                        end
                    end
                end
            end
            default: lrn_next = LRN_IDLE;
        endcase
        if (cmd_clr) begin
            // a violation landing with the command still pauses: set wins
            paused_next = pause_evt; // [RULE_14]
            fail_next   = pause_evt ? fail_next : 16'h0;
        end
        if (lead_wr) begin
            lead_next = (hwdata[WW-1:0] > MAX_WEIGHT) ? MAX_WEIGHT : hwdata[WW-1:0];
        end
        // w1c: a fresh event in the same cycle wins over the clear unless its bit was already set
        if (wr_en && aaddr_reg == OFS_IRQ_STAT) begin
            istat_next = istat_next & ~(hwdata[2:0] & ~(istat_next & ~istat_reg));
        end
        irq_next = |(istat_next & imask_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait state, okay only
    always_comb begin
        ctrl_next     = ctrl_reg;
        target_next   = target_reg;
        band_next     = band_reg;
        rearm_next    = rearm_reg;
        factor_next   = factor_reg;
        settle_next   = settle_reg;
        interval_next = interval_reg;
        tol_next      = tol_reg;
        tolerance_fail_count_next   = tolerance_fail_count_reg;
        imask_next    = imask_reg;
        aaddr_next    = addr_ok ? haddr[7:0] : aaddr_reg;
        awr_next      = addr_ok && hwrite;
        hrdata_next   = 32'h0;
        rdy_next      = 1'b1;
        if (wr_en) begin
            case (aaddr_reg)
                OFS_CTRL:     ctrl_next = hwdata[9:0];
                OFS_TARGET:   target_next = (hwdata[WW-1:0] > MAX_WEIGHT) ? MAX_WEIGHT : hwdata[WW-1:0]; // [RULE_16]
                OFS_BAND:     band_next = hwdata[WW-1:0];
                OFS_REARM:    rearm_next = hwdata[WW-1:0];
                OFS_FACTOR:   factor_next = hwdata[WW-1:0];
                OFS_LEARN: begin
                    settle_next   = hwdata[15:0];
                    interval_next = hwdata[31:16];
                end
                OFS_TOL:      tol_next = hwdata[WW-1:0];
                OFS_TOLERANCE_FAIL_COUNT:   tolerance_fail_count_next = hwdata[15:0];
                OFS_IRQ_MASK: imask_next = hwdata[2:0];
                default:      ctrl_next = ctrl_reg;
            endcase
        end
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL:     hrdata_next = {22'h0, ctrl_reg};
                OFS_TARGET:   hrdata_next = {8'h0, target_reg};
                OFS_BAND:     hrdata_next = {8'h0, band_reg};
                OFS_REARM:    hrdata_next = {8'h0, rearm_reg};
                OFS_LEAD:     hrdata_next = {8'h0, lead_next};
                OFS_FACTOR:   hrdata_next = {8'h0, factor_reg};
                OFS_LEARN:    hrdata_next = {interval_reg, settle_reg};
                OFS_TOL:      hrdata_next = {8'h0, tol_reg};
                OFS_TOLERANCE_FAIL_COUNT:   hrdata_next = {16'h0, tolerance_fail_count_reg};
                OFS_STATUS:   hrdata_next = {fail_reg, 11'h0, lrn_reg, armed_reg, paused_reg, out_reg};
                OFS_IRQ_STAT: hrdata_next = {29'h0, istat_reg};
                OFS_IRQ_MASK: hrdata_next = {29'h0, imask_reg};
                default:      hrdata_next = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= RST_CTRL;       target_reg <= RST_ZERO;     band_reg <= RST_ZERO;
            rearm_reg <= RST_ZERO;      lead_reg <= RST_ZERO;       factor_reg <= RST_FACTOR;
            settle_reg <= RST_SETTLE;   interval_reg <= RST_INTERVAL;
            tol_reg <= RST_ZERO;        tolerance_fail_count_reg <= RST_TOLERANCE_FAIL_COUNT;   istat_reg <= 3'h0;
            imask_reg <= 3'h0;          aaddr_reg <= 8'h00;         awr_reg <= 1'b0;
            hrdata_reg <= 32'h0;        irq_reg <= 1'b0;            out_reg <= 1'b0;
            armed_reg <= 1'b1;          paused_reg <= 1'b0;         prev_w_reg <= RST_ZERO;
            fail_reg <= 16'h0;          bcnt_reg <= 16'h0;          tenth_reg <= 16'h0;
            tick_reg <= 32'h0;          capt_reg <= RST_ZERO;       lrn_reg <= LRN_IDLE;
            rdy_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;      target_reg <= target_next;  band_reg <= band_next;
            rearm_reg <= rearm_next;    lead_reg <= lead_next;      factor_reg <= factor_next;
            settle_reg <= settle_next;  interval_reg <= interval_next;
            tol_reg <= tol_next;        tolerance_fail_count_reg <= tolerance_fail_count_next;  istat_reg <= istat_next;
            imask_reg <= imask_next;    aaddr_reg <= aaddr_next;    awr_reg <= awr_next;
            hrdata_reg <= hrdata_next;  irq_reg <= irq_next;        out_reg <= out_next;
            armed_reg <= armed_next;    paused_reg <= paused_next;  prev_w_reg <= prev_w_next;
            fail_reg <= fail_next;      bcnt_reg <= bcnt_next;      tenth_reg <= tenth_next;
            tick_reg <= tick_next;      capt_reg <= capt_next;      lrn_reg <= lrn_next;
            rdy_reg <= rdy_next;
        end
    end

    assign hrdata       = hrdata_reg;
    assign hreadyout    = rdy_reg;
    assign hresp        = 1'b0;
    assign setpoint_out = out_reg;
    assign batch_paused = paused_reg;
    assign irq          = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_disarmed_then_armed;
        !armed_reg ##1 armed_reg;
    endsequence

    property p_out_stable;
        !sample_valid |=> $stable(out_reg);
    endproperty
    a_out_stable: assert property (p_out_stable) else $error("output moved without sample"); // [RULE_17]

    property p_above_trip;
        sample_valid && cond == COND_ABOVE && lmode == LEAD_OFF && ctrl_reg[CTRL_BATCH_BIT] && weight >= target_reg
            |=> !out_reg;
    endproperty
    a_above_trip: assert property (p_above_trip) else $error("above output on at target"); // [RULE_03]

    property p_below_trip;
        sample_valid && cond == COND_BELOW && lmode == LEAD_OFF && ctrl_reg[CTRL_BATCH_BIT] && weight < target_reg
            |=> !out_reg;
    endproperty
    a_below_trip: assert property (p_below_trip) else $error("below output on under target"); // [RULE_04]

    property p_rearm;
        s_disarmed_then_armed |-> $past(sample_valid && beyond);
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearmed inside margin"); // [RULE_06]

    property p_pause_hold;
        paused_reg && !cmd_clr |=> paused_reg;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause dropped without command"); // [RULE_14]

    property p_pause_clear;
        cmd_clr && !pause_evt |=> !paused_reg;
    endproperty
    a_pause_clear: assert property (p_pause_clear) else $error("pause not cleared"); // [RULE_14]

    property p_pause_set;
        pause_evt |=> paused_reg;
    endproperty
    a_pause_set: assert property (p_pause_set) else $error("violation did not pause"); // [RULE_15]

    property p_zero_count;
        $rose(paused_reg) |-> $past(tolerance_fail_count_reg) != 16'h0 && $past(lrn_reg) == LRN_UPDATE;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("paused with zero fail count"); // [RULE_15]

    property p_lead_clamp;
        lead_reg <= MAX_WEIGHT;
    endproperty
    a_lead_clamp: assert property (p_lead_clamp) else $error("lead above max weight"); // [RULE_18]

    property p_tol_skip;
        lrn_reg == LRN_UPDATE && !in_tol && !lead_wr |=> $stable(lead_reg);
    endproperty
    a_tol_skip: assert property (p_tol_skip) else $error("lead learned out of tolerance"); // [RULE_13]
endmodule

// ===== hw/wsc_pkg.sv
// package for the weight setpoint comparator: register map, reset values, enums
// assumes a 50 MHz hclk and 32-bit ahb-lite register access
package wsc_pkg;
    localparam int WW = 24;
    localparam logic [WW-1:0] MAX_WEIGHT = 24'h98967f;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TARGET   = 8'h04;
    localparam logic [7:0] OFS_BAND     = 8'h08;
    localparam logic [7:0] OFS_REARM    = 8'h0c;
    localparam logic [7:0] OFS_LEAD     = 8'h10;
    localparam logic [7:0] OFS_FACTOR   = 8'h14;
    localparam logic [7:0] OFS_LEARN    = 8'h18;
    localparam logic [7:0] OFS_TOL      = 8'h1c;
    localparam logic [7:0] OFS_TOLERANCE_FAIL_COUNT   = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFS_CMD      = 8'h30;
    ////////////////////////////////////////////////////////////////////////
    localparam int CTRL_COND_LSB  = 0;
    localparam int CTRL_LEAD_LSB  = 2;
    localparam int CTRL_SCALE_LSB = 4;
    localparam int CTRL_BATCH_BIT = 8;
    localparam int CTRL_EN_BIT    = 9;
    localparam int IRQ_TRIP_BIT   = 0;
    localparam int IRQ_PAUSE_BIT  = 1;
    localparam int IRQ_LEARN_BIT  = 2;
    localparam int CMD_RESTART_BIT = 0;
    localparam int CMD_RESET_BIT   = 1;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [9:0]    RST_CTRL     = 10'h000;
    localparam logic [WW-1:0] RST_FACTOR   = 24'h07a120;
    localparam logic [15:0]   RST_SETTLE   = 16'h0000;
    localparam logic [15:0]   RST_INTERVAL = 16'h0001;
    localparam logic [15:0]   RST_TOLERANCE_FAIL_COUNT   = 16'h0001;
    localparam logic [WW-1:0] RST_ZERO     = 24'h000000;
    localparam int FACTOR_ONE = 1000000;
    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETTLE_UNIT_NS = 100000000;
    localparam int SETTLE_TICK_CYCLES = SETTLE_UNIT_NS / CLK_PERIOD_NS;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {COND_ABOVE, COND_BELOW, COND_INSIDE, COND_OUTSIDE} wsc_cond_e;
    typedef enum logic [1:0] {LEAD_OFF, LEAD_FIXED, LEAD_ADAPT, LEAD_RATE} wsc_lead_e;
    typedef enum logic [1:0] {LRN_IDLE, LRN_SETTLE, LRN_UPDATE} wsc_lrn_e;
endpackage

// ===== sim/wsc_scale_model.sv
// scale weight source and batch sequencer stand-in for the setpoint comparator
// assumes NUM_SCALES of 4, 24-bit weights, all signals on hclk
module wsc_scale_model (
    input  wire logic        hclk,
    output logic      [95:0] scale_weight,
    output logic             sample_valid,
    output logic             standstill,
    output logic             batch_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scale_weight = 96'h0;
        sample_valid = 1'b0;
        standstill   = 1'b0;
        batch_done   = 1'b0;
    end
    //////////////////////////////////////////
    // unselected scales carry the inverse, so a wrong pick shows
    task automatic sample(input int s, input logic [23:0] w, input logic ss);
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            scale_weight[i*24+:24] <= (i == s) ? w : ~w;
        end
        sample_valid <= 1'b1;
        standstill   <= ss;
        @(posedge hclk);
        sample_valid <= 1'b0;
        standstill   <= 1'b0;
    endtask
    // one-cycle end-of-batch pulse
    task automatic batch();
        @(posedge hclk);
        batch_done <= 1'b1;
        @(posedge hclk);
        batch_done <= 1'b0;
    endtask
endmodule

// ===== sim/test_weight_setpoint_comparator.sv
// self-checking bench for the setpoint comparator over ahb-lite
// assumes wsc_pkg, wsc_comparator and wsc_scale_model compiled first
module test_weight_setpoint_comparator;
    timeunit 1ns;
    timeprecision 1ps;
    import wsc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [95:0] scale_weight;
    logic        sample_valid, standstill, batch_done, setpoint_out, batch_paused, irq;
    int          n_fail, cmp_count, cyc;
    assign hready = hreadyout;
    wsc_comparator #(.NUM_SCALES(4), .TICK_CYCLES(10)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scale_weight(scale_weight),
        .sample_valid(sample_valid), .standstill(standstill), .batch_done(batch_done),
        .setpoint_out(setpoint_out), .batch_paused(batch_paused), .irq(irq));
    wsc_scale_model u_src (.hclk(hclk), .scale_weight(scale_weight), .sample_valid(sample_valid),
        .standstill(standstill), .batch_done(batch_done));
    //////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // address phase held until hready, then data phase until hready
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(nm, r, exp);
    endtask
    // sample on one scale, then look at the output it produced
    task automatic smp(input int s, input logic [23:0] w, input logic exp);
        u_src.sample(s, w, 1'b0);
        tick(1);
        chk("setpoint_out", setpoint_out, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    //////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // hang guard: whole run needs well under 3000 cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        hsize = 3'h2;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        tick(10);
        hresetn <= 1'b1;
        rdchk("factor", OFS_FACTOR, 32'h0007a120);
        rdchk("learn", OFS_LEARN, 32'h00010000);
        rdchk("tolerance_fail_count", OFS_TOLERANCE_FAIL_COUNT, 32'h00000001);
        rdchk("unmapped", 8'h3c, 32'h0);
        rdchk("status", OFS_STATUS, 32'h00000004);
        $display("test reset_values done");
        wr(OFS_TARGET, 32'h3e8);
        wr(OFS_LEAD, 32'h64);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CTRL, 32'h314);
        smp(1, 24'h352, 1'b1);
        smp(1, 24'h383, 1'b1);
        smp(1, 24'h384, 1'b0);
        chk("irq", irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq", irq, 1'b0);
        $display("test above_fixed_lead done");
        wr(OFS_REARM, 32'h32);
        wr(OFS_BAND, 32'h64);
        wr(OFS_CTRL, 32'h221);
        u_src.sample(2, 24'h384, 1'b0);
        smp(2, 24'h384, 1'b1);
        smp(2, 24'h3e8, 1'b0);
        smp(2, 24'h3de, 1'b0);
        u_src.sample(2, 24'h3ac, 1'b0);
        smp(2, 24'h3ac, 1'b1);
        wr(OFS_CTRL, 32'h222);
        smp(2, 24'h44c, 1'b1);
        smp(2, 24'h44d, 1'b0);
        wr(OFS_CTRL, 32'h223);
        u_src.sample(2, 24'h4b0, 1'b0);
        smp(2, 24'h4b0, 1'b1);
        $display("test window_rearm done");
        wr(OFS_REARM, 32'h0);
        wr(OFS_TOL, 32'h3e8);
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h4);
        wr(OFS_CTRL, 32'h308);
        u_src.batch();
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        rdchk("lead", OFS_LEAD, 32'h78);
        chk("irq", irq, 1'b1);
        u_src.batch();
        u_src.sample(0, 24'h3c0, 1'b1);
        tick(4);
        rdchk("lead", OFS_LEAD, 32'h64);
        $display("test adaptive_lead done");
        wr(OFS_LEARN, 32'h00010002);
        u_src.batch();
        tick(40);
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        rdchk("lead", OFS_LEAD, 32'h64);
        wr(OFS_LEARN, 32'h00020000);
        u_src.batch();
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        rdchk("lead", OFS_LEAD, 32'h64);
        u_src.batch();
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        rdchk("lead", OFS_LEAD, 32'h78);
        $display("test settle_interval done");
        wr(OFS_TOL, 32'h0a);
        wr(OFS_TOLERANCE_FAIL_COUNT, 32'h2);
        wr(OFS_LEARN, 32'h00010000);
        u_src.batch();
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        chk("batch_paused", batch_paused, 1'b0);
        u_src.batch();
        u_src.sample(0, 24'h410, 1'b1);
        tick(4);
        chk("batch_paused", batch_paused, 1'b1);
        rdchk("lead", OFS_LEAD, 32'h78);
        wr(OFS_CMD, 32'h1);
        tick(2);
        chk("batch_paused", batch_paused, 1'b0);
        $display("test tolerance_pause done");
        wr(OFS_TARGET, 32'hffffff);
        rdchk("target", OFS_TARGET, 32'h0098967f);
        wr(OFS_TARGET, 32'h3e8);
        wr(OFS_CTRL, 32'h30c);
        u_src.sample(0, 24'h2bc, 1'b0);
        smp(0, 24'h2ee, 1'b1);
        smp(0, 24'h334, 1'b0);
        wr(OFS_CTRL, 32'h300);
        u_src.sample(0, 24'h384, 1'b0);
        smp(0, 24'h3e7, 1'b1);
        smp(0, 24'h3e8, 1'b0);
        wr(OFS_CTRL, 32'h301);
        u_src.sample(0, 24'h44c, 1'b0);
        smp(0, 24'h3e8, 1'b1);
        smp(0, 24'h3e7, 1'b0);
        $display("test rate_and_plain_batch done");
        stop_test();
    end
endmodule
